// ==== hdl/tcr_regs.sv ====
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
//
// Contract
// - Register 07h holds threshold bits 23 down to 8, all sixteen bits.
// - Register 08h upper byte holds threshold bits 7 down to 0.
// - Reserved bits are read-only and read as zero.
// - Register 08h bits 3:0 hold the global DC filter setting, reset zero.
// - Register 09h bits 15:6 hold signed ten-bit channel 0 phase delay.
// - Bit 2 set turns channel 0 DC filtering off; clear follows global.
// - Bits 1:0 route channel 0 input: pins, shorted, positive or negative test.
// - Reset returns registers 07h, 08h and 09h to zero.
// - Threshold feeds detect mode; detection after a selectable exceedance count.
module tcr_regs
  import tcr_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        reset,
  // Register port.
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [15:0] reg_rdata,
  // Current-detect interface.
  input  wire logic signed [23:0] sample_magnitude,
  input  wire logic        sample_valid,
  output logic signed [23:0] detect_threshold,
  output logic             detect_event,
  // Channel 0 controls.
  output logic      [3:0]  global_dc_filter_setting,
  output logic signed [9:0] channel0_phase_delay,
  output logic             channel0_dc_filter_off,
  output logic      [3:0]  channel0_dc_filter_eff,
  output logic      [1:0]  channel0_input_select
);

  logic [15:0] high_q;
  logic [15:0] low_q;
  logic [15:0] ch0_q;
  logic [15:0] dcfg_q;
  logic [15:0] rdata_d;
  logic [15:0] rdata_q;
  logic        sel_high;
  logic        sel_low;
  logic        sel_ch0;
  logic        sel_dcfg;
  logic signed [23:0] thresh_now;
  logic        exceed;
  logic        detect_raw;

  assign sel_high = reg_write && (reg_addr == TCR_ADDR_THRESH_HIGH);
  assign sel_low  = reg_write && (reg_addr == TCR_ADDR_THRESH_LOW);
  assign sel_ch0  = reg_write && (reg_addr == TCR_ADDR_CH0_CONFIG);
  assign sel_dcfg = reg_write && (reg_addr == TCR_ADDR_DETECT_CFG);

  // Threshold high word: all bits writable.
  tcr_reg16 #(.RESET_VALUE(TCR_RESET_THRESH_HIGH), .WRITE_MASK(16'hffff)) u_high (
    .clk     (clk),
    .reset   (reset),
    .wr_en   (sel_high),
    .wr_data (reg_wdata),
    .value_q (high_q)
  );

  // Threshold low byte plus DC filter setting; bits 7:4 masked.
  tcr_reg16 #(.RESET_VALUE(TCR_RESET_THRESH_LOW), .WRITE_MASK(TCR_MASK_THRESH_LOW)) u_low (
    .clk     (clk),
    .reset   (reset),
    .wr_en   (sel_low),
    .wr_data (reg_wdata),
    .value_q (low_q)
  );

  // Channel 0 configuration; bits 5:3 masked.
  tcr_reg16 #(.RESET_VALUE(TCR_RESET_CH0_CONFIG), .WRITE_MASK(TCR_MASK_CH0_CONFIG)) u_ch0 (
    .clk     (clk),
    .reset   (reset),
    .wr_en   (sel_ch0),
    .wr_data (reg_wdata),
    .value_q (ch0_q)
  );

  // Detect enable and exceedance count select.
  tcr_reg16 #(.RESET_VALUE(TCR_RESET_DETECT_CFG), .WRITE_MASK(TCR_MASK_DETECT_CFG)) u_dcfg (
    .clk     (clk),
    .reset   (reset),
    .wr_en   (sel_dcfg),
    .wr_data (reg_wdata),
    .value_q (dcfg_q)
  );

  // Halves concatenate with the upper word on top, giving a signed value.
  assign thresh_now = {high_q, low_q[TCR_LOW_THRESH_MSB:TCR_LOW_THRESH_LSB]};

  // Exceedance compares the signed sample against the stored threshold.
  assign exceed = sample_valid && (sample_magnitude > thresh_now);

  tcr_detect_count #(.CNT_W(8)) u_count (
    .clk      (clk),
    .reset    (reset),
    .enable   (dcfg_q[TCR_DET_EN_BIT]),
    .num_sel  (dcfg_q[TCR_DET_NUM_MSB:TCR_DET_NUM_LSB]),
    .exceed   (exceed),
    .detect_q (detect_raw)
  );

  // Read mux; unmapped addresses read zero.
  assign rdata_d = !reg_read                        ? 16'h0000 :
                   (reg_addr == TCR_ADDR_THRESH_HIGH) ? high_q :
                   (reg_addr == TCR_ADDR_THRESH_LOW)  ? low_q :
                   (reg_addr == TCR_ADDR_CH0_CONFIG)  ? ch0_q :
                   (reg_addr == TCR_ADDR_DETECT_CFG)  ? dcfg_q : 16'h0000;

  // Outputs are registered copies, so the downstream view lags a write by one cycle.
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q                  <= 16'h0000;
      detect_threshold         <= 24'sh000000;
      global_dc_filter_setting <= 4'h0;
      channel0_phase_delay     <= 10'sh000;
      channel0_dc_filter_off   <= 1'b0;
      channel0_dc_filter_eff   <= 4'h0;
      channel0_input_select    <= 2'h0;
      detect_event             <= 1'b0;
    end else begin
      rdata_q                  <= rdata_d;
      detect_threshold         <= thresh_now;
      global_dc_filter_setting <= low_q[TCR_LOW_DCF_MSB:TCR_LOW_DCF_LSB];
      channel0_phase_delay     <= ch0_q[TCR_CH0_PHASE_MSB:TCR_CH0_PHASE_LSB];
      channel0_dc_filter_off   <= ch0_q[TCR_CH0_DCOFF_BIT];
      channel0_dc_filter_eff   <= ch0_q[TCR_CH0_DCOFF_BIT] ? 4'h0 : low_q[TCR_LOW_DCF_MSB:TCR_LOW_DCF_LSB];
      channel0_input_select    <= ch0_q[TCR_CH0_MUX_MSB:TCR_CH0_MUX_LSB];
      detect_event             <= detect_raw;
    end
  end

  assign reg_rdata = rdata_q;

  // Assertions.
  chk_low_reserved_zero: assert property (@(posedge clk) disable iff (reset)
    reg_read && reg_addr == TCR_ADDR_THRESH_LOW |=> reg_rdata[7:4] == 4'h0)
    else $error("Reserved bits of threshold low register not zero.");

  chk_ch0_reserved_zero: assert property (@(posedge clk) disable iff (reset)
    reg_read && reg_addr == TCR_ADDR_CH0_CONFIG |=> reg_rdata[5:3] == 3'h0)
    else $error("Reserved bits of channel 0 config not zero.");

  chk_high_write_read: assert property (@(posedge clk) disable iff (reset)
    sel_high ##1 (reg_read && reg_addr == TCR_ADDR_THRESH_HIGH && !reg_write)
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("Threshold high word did not read back.");

  chk_low_thresh_path: assert property (@(posedge clk) disable iff (reset)
    sel_low |=> ##1 detect_threshold[7:0] == $past(reg_wdata[15:8], 2))
    else $error("Threshold low byte not presented.");

  chk_dc_setting_path: assert property (@(posedge clk) disable iff (reset)
    sel_low |=> ##1 global_dc_filter_setting == $past(reg_wdata[3:0], 2))
    else $error("Global DC filter setting not updated.");

  chk_phase_path: assert property (@(posedge clk) disable iff (reset)
    sel_ch0 |=> ##1 channel0_phase_delay == $past(reg_wdata[15:6], 2))
    else $error("Channel 0 phase delay not updated.");

  chk_dc_off_gate: assert property (@(posedge clk) disable iff (reset)
    channel0_dc_filter_off |-> channel0_dc_filter_eff == 4'h0)
    else $error("Channel 0 DC filter active while turned off.");

  chk_mux_path: assert property (@(posedge clk) disable iff (reset)
    sel_ch0 |=> ##1 channel0_input_select == $past(reg_wdata[1:0], 2))
    else $error("Channel 0 input select not updated.");

  chk_reset_zero: assert property (@(posedge clk)
    $past(reset) |-> high_q == 16'h0000 && low_q == 16'h0000 && ch0_q == 16'h0000)
    else $error("Registers not zero after reset.");

  chk_detect_off: assert property (@(posedge clk) disable iff (reset)
    !dcfg_q[TCR_DET_EN_BIT] ##1 !dcfg_q[TCR_DET_EN_BIT] |=> !detect_event)
    else $error("Detection raised while detect mode disabled.");

  // Write followed at once by a read returns the masked value, so the mask is checked at the port.
  chk_low_write_read: assert property (@(posedge clk) disable iff (reset)
    sel_low ##1 (reg_read && reg_addr == TCR_ADDR_THRESH_LOW && !reg_write)
    |=> reg_rdata == ($past(reg_wdata, 2) & TCR_MASK_THRESH_LOW))
    else $error("Threshold low register did not read back.");

  chk_ch0_write_read: assert property (@(posedge clk) disable iff (reset)
    sel_ch0 ##1 (reg_read && reg_addr == TCR_ADDR_CH0_CONFIG && !reg_write)
    |=> reg_rdata == ($past(reg_wdata, 2) & TCR_MASK_CH0_CONFIG))
    else $error("Channel 0 config did not read back.");

  // A register must not move unless its own address is written.
  chk_high_hold: assert property (@(posedge clk) disable iff (reset)
    !sel_high |=> high_q == $past(high_q))
    else $error("Threshold high word changed without a write.");

  chk_low_hold: assert property (@(posedge clk) disable iff (reset)
    !sel_low |=> low_q == $past(low_q))
    else $error("Threshold low register changed without a write.");

  chk_ch0_hold: assert property (@(posedge clk) disable iff (reset)
    !sel_ch0 |=> ch0_q == $past(ch0_q))
    else $error("Channel 0 config changed without a write.");

  chk_reserved_stored: assert property (@(posedge clk) disable iff (reset)
    low_q[7:4] == 4'h0 && ch0_q[5:3] == 3'h0)
    else $error("Reserved bits stored as nonzero.");

  chk_eff_follows: assert property (@(posedge clk) disable iff (reset)
    !channel0_dc_filter_off |-> channel0_dc_filter_eff == global_dc_filter_setting)
    else $error("Channel 0 DC filter does not follow the global setting.");

  chk_thresh_concat: assert property (@(posedge clk) disable iff (reset)
    !$past(reset) |-> detect_threshold == {$past(high_q), $past(low_q[15:8])})
    else $error("Threshold concatenation wrong.");

endmodule // tcr_regs

// ==== hdl/tcr_pkg.sv ====
package tcr_pkg;

  // Register offsets (word addresses on the plain register port).
  localparam logic [7:0] TCR_ADDR_THRESH_HIGH = 8'h07;
  localparam logic [7:0] TCR_ADDR_THRESH_LOW  = 8'h08;
  localparam logic [7:0] TCR_ADDR_CH0_CONFIG  = 8'h09;
  localparam logic [7:0] TCR_ADDR_DETECT_CFG  = 8'h20;

  // Reset values.
  localparam logic [15:0] TCR_RESET_THRESH_HIGH = 16'h0000;
  localparam logic [15:0] TCR_RESET_THRESH_LOW  = 16'h0000;
  localparam logic [15:0] TCR_RESET_CH0_CONFIG  = 16'h0000;
  localparam logic [15:0] TCR_RESET_DETECT_CFG  = 16'h0000;

  // Field positions.
  localparam int TCR_LOW_THRESH_LSB = 8;
  localparam int TCR_LOW_THRESH_MSB = 15;
  localparam int TCR_LOW_DCF_LSB    = 0;
  localparam int TCR_LOW_DCF_MSB    = 3;
  localparam int TCR_CH0_PHASE_LSB  = 6;
  localparam int TCR_CH0_PHASE_MSB  = 15;
  localparam int TCR_CH0_DCOFF_BIT  = 2;
  localparam int TCR_CH0_MUX_LSB    = 0;
  localparam int TCR_CH0_MUX_MSB    = 1;
  localparam int TCR_DET_EN_BIT     = 0;
  localparam int TCR_DET_NUM_LSB    = 4;
  localparam int TCR_DET_NUM_MSB    = 6;

  // Writable bit masks; reserved bits are forced to zero.
  localparam logic [15:0] TCR_MASK_THRESH_LOW = 16'hff0f;
  localparam logic [15:0] TCR_MASK_CH0_CONFIG = 16'hffc7;
  localparam logic [15:0] TCR_MASK_DETECT_CFG = 16'h0071;

  // Channel 0 input routing codes.
  typedef enum logic [1:0] {
    TCR_MUX_PINS    = 2'h0,
    TCR_MUX_SHORTED = 2'h1,
    TCR_MUX_POS_DC  = 2'h2,
    TCR_MUX_NEG_DC  = 2'h3
  } tcr_mux_t;

endpackage

// ==== hdl/tcr_reg16.sv ====
`timescale 1ns/10ps
module tcr_reg16
  import tcr_pkg::*;
#(
  parameter logic [15:0] RESET_VALUE = 16'h0000,
  parameter logic [15:0] WRITE_MASK  = 16'hffff
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        reset,
  // Write side.
  input  wire logic        wr_en,
  input  wire logic [15:0] wr_data,
  // Stored value.
  output logic      [15:0] value_q
);

  logic [15:0] value_d;

  assign value_d = wr_en ? (wr_data & WRITE_MASK) : value_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      value_q <= RESET_VALUE;
    end else begin
      value_q <= value_d;
    end
  end

endmodule // tcr_reg16

// ==== hdl/tcr_detect_count.sv ====
`timescale 1ns/10ps
module tcr_detect_count
  import tcr_pkg::*;
#(
  parameter int CNT_W = 8
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        reset,
  // Control.
  input  wire logic        enable,
  input  wire logic [2:0]  num_sel,
  input  wire logic        exceed,
  // Result.
  output logic             detect_q
);

  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic [CNT_W-1:0] target;
  logic             hit;

  // Exceedance target is a power of two from 1 to 128.
  assign target  = CNT_W'(1) << num_sel;
  assign hit     = enable && exceed && ((count_q + CNT_W'(1)) >= target);
  assign count_d = (!enable || hit) ? '0 : (exceed ? count_q + CNT_W'(1) : count_q);

  always_ff @(posedge clk) begin
    if (reset) begin
      count_q  <= '0;
      detect_q <= 1'b0;
    end else begin
      count_q  <= count_d;
      detect_q <= hit;
    end
  end

endmodule // tcr_detect_count

// ==== test/tcr_regs_tb.sv ====
`timescale 1ns/10ps
module testbench;
  import tcr_pkg::*;

  logic                   clk;
  logic                   reset;
  logic            [7:0]  reg_addr;
  logic            [15:0] reg_wdata;
  logic                   reg_write;
  logic                   reg_read;
  logic            [15:0] reg_rdata;
  logic signed     [23:0] sample_magnitude;
  logic                   sample_valid;
  logic signed     [23:0] detect_threshold;
  logic                   detect_event;
  logic            [3:0]  global_dc_filter_setting;
  logic signed     [9:0]  channel0_phase_delay;
  logic                   channel0_dc_filter_off;
  logic            [3:0]  channel0_dc_filter_eff;
  logic            [1:0]  channel0_input_select;
  int                     fail_count;
  int                     total_checks;

  tcr_regs i_tcr_regs (
    .clk                      (clk),
    .reset                    (reset),
    .reg_addr                 (reg_addr),
    .reg_wdata                (reg_wdata),
    .reg_write                (reg_write),
    .reg_read                 (reg_read),
    .reg_rdata                (reg_rdata),
    .sample_magnitude         (sample_magnitude),
    .sample_valid             (sample_valid),
    .detect_threshold         (detect_threshold),
    .detect_event             (detect_event),
    .global_dc_filter_setting (global_dc_filter_setting),
    .channel0_phase_delay     (channel0_phase_delay),
    .channel0_dc_filter_off   (channel0_dc_filter_off),
    .channel0_dc_filter_eff   (channel0_dc_filter_eff),
    .channel0_input_select    (channel0_input_select)
  );

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic cmp_reg(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: register read %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_out(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: output %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  // A write followed at once by a read of the same address, the tightest spacing the port allows.
  task automatic wr_rd(input logic [7:0] a, input logic [15:0] d, input logic [15:0] exp);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    reg_read  <= 1'b1;
    @(posedge clk);
    reg_read  <= 1'b0;
    #1;
    cmp_reg(reg_rdata, exp);
    @(posedge clk);
    #1;
    cmp_reg(reg_rdata, 16'h0000);
  endtask

  // The read data stand only in the cycle after the strobe, so the idle value is checked one cycle later too.
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    cmp_reg(reg_rdata, exp);
    @(posedge clk);
    #1;
    cmp_reg(reg_rdata, 16'h0000);
  endtask

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic sample(input logic signed [23:0] s, input logic exp_event);
    @(posedge clk);
    sample_magnitude <= s;
    sample_valid     <= 1'b1;
    @(posedge clk);
    sample_valid     <= 1'b0;
    // The counter flags on the counting edge and the output flop adds one more cycle.
    @(posedge clk);
    #1;
    cmp_out({23'h0, detect_event}, {23'h0, exp_event});
  endtask

  task automatic check_all_zero();
    rd(TCR_ADDR_THRESH_HIGH, 16'h0000);
    rd(TCR_ADDR_THRESH_LOW, 16'h0000);
    rd(TCR_ADDR_CH0_CONFIG, 16'h0000);
    cmp_out(detect_threshold, 24'h000000);
    cmp_out({14'h0, channel0_phase_delay}, 24'h000000);
    cmp_out({20'h0, global_dc_filter_setting}, 24'h000000);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    conclude();
  end

  initial begin
    reset = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
    sample_magnitude = 24'h000000;
    sample_valid = 1'b0;
    fail_count = 0;
    total_checks = 0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    check_all_zero();
    wr_rd(TCR_ADDR_THRESH_HIGH, 16'h1234, 16'h1234);
    wr_rd(TCR_ADDR_THRESH_LOW, 16'habfd, 16'hab0d);
    settle();
    cmp_out(detect_threshold, 24'h1234ab);
    cmp_out({20'h0, global_dc_filter_setting}, 24'h00000d);
    // Phase 201h sits at 15:6; the reserved bits 5:3 are written as ones and must not stick.
    wr_rd(TCR_ADDR_CH0_CONFIG, 16'h807f, 16'h8047);
    settle();
    cmp_out({14'h0, channel0_phase_delay}, 24'h000201);
    cmp_out({23'h0, channel0_dc_filter_off}, 24'h000001);
    cmp_out({20'h0, channel0_dc_filter_eff}, 24'h000000);
    for (int m = 0; m < 4; m++) begin
      wr(TCR_ADDR_CH0_CONFIG, {14'h0, 2'(m)});
      settle();
      cmp_out({22'h0, channel0_input_select}, 24'(m));
      cmp_out({20'h0, channel0_dc_filter_eff}, 24'h00000d);
    end
    wr(8'h30, 16'hffff);
    rd(8'h30, 16'h0000);
    rd(TCR_ADDR_THRESH_HIGH, 16'h1234);
    // Two exceedances are asked for; a sample equal to the threshold does not count.
    wr(TCR_ADDR_DETECT_CFG, 16'h0011);
    sample(24'h1234ab, 1'b0);
    sample(24'h1234ac, 1'b0);
    sample(24'h1234ac, 1'b1);
    @(posedge clk);
    #1;
    cmp_out({23'h0, detect_event}, 24'h000000);
    @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    check_all_zero();
    conclude();
  end
endmodule // testbench
